// file: hdl/css_pkg.sv
// constants, types and register map of the clock source switcher
// assumes a 16-bit plain register port and one system clock
package css_pkg;

  // register addresses on the plain port
  localparam logic [1:0] ADDR_CTRL_LO = 2'h0; // osc_control low byte
  localparam logic [1:0] ADDR_CTRL_HI = 2'h1; // osc_control high byte
  localparam logic [1:0] ADDR_TRIM = 2'h2; // fast_rc_trim

  // unlock keys for the guarded control bytes
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9a;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;

  // osc_control bit positions
  localparam int BIT_SWITCH_REQ = 0;
  localparam int BIT_SEC_EN = 1;
  localparam int BIT_CLK_FAIL = 3;
  localparam int BIT_PLL_LOCK = 5;
  localparam int BIT_SEL_LOCK = 7;
  localparam int NEXT_LSB = 8;
  localparam int CUR_LSB = 12;

  // trim field
  localparam int TRIM_W = 6;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // source selection codes
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY = 3'h2;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] SRC_RESERVED = 3'h6;
  localparam logic [2:0] SRC_FAST_RC_DIV = 3'h7;

  // oscillator enable vector bit positions
  localparam int EN_FAST_RC = 0;
  localparam int EN_PRIMARY = 1;
  localparam int EN_SECONDARY = 2;
  localparam int EN_LOW_POWER_RC = 3;
  localparam int EN_PLL = 4;
  localparam int EN_W = 5;

  // new-clock cycles to wait before changing over
  localparam int NEW_CLK_CYCLES = 10;

  typedef enum logic [2:0] {
    SW_IDLE,
    SW_START,
    SW_WAIT_READY,
    SW_COUNT,
    SW_DONE
  } css_state_e;

  // configuration bits, static after power-up
  typedef struct packed {
    logic switch_enable_cfg; // 0 enables switching and fail-safe monitor
    logic [2:0] initial_source_cfg;
    logic [1:0] primary_submode_cfg;
  } css_cfg_s;

endpackage

// file: hdl/css_switcher.sv
// clock source switcher: guarded osc_control register, trim register, switch sequencer
// assumes config bits stable from reset, oscillator status pins asynchronous
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
module css_switcher
(
  input wire logic CLK_SYS_IN, // 25 MHz system clock
  input wire logic RST_IN, // async reset, active high
  input wire logic CE_IN, // clock enable, freezes state when low
  input wire logic [1:0] ADDR_IN, // register address
  input wire logic [15:0] WDATA_IN, // write data
  input wire logic WR_IN, // write strobe
  input wire logic RD_IN, // read strobe
  output logic [15:0] RDATA_OUT, // read data, cycle after strobe
  input wire css_pkg::css_cfg_s CFG_IN, // configuration bits
  input wire logic WDT_EN_IN, // watchdog enabled, keeps low-power rc
  input wire logic SRC_READY_IN, // async: started source past startup
  input wire logic PLL_LOCK_IN, // async: pll lock detect
  input wire logic NEW_CLK_IN, // async: the new source clock itself
  input wire logic CLOCK_FAIL_IN, // async: monitor saw a clock failure
  output logic [css_pkg::EN_W-1:0] OSC_EN_OUT, // oscillator enables
  output logic [2:0] SYS_CLK_SEL_OUT, // system clock source select
  output logic [1:0] PRI_SUBMODE_OUT, // primary submode to the oscillator
  output logic [css_pkg::TRIM_W-1:0] TRIM_OUT // fast rc trim
);

  // oscillators that a source code needs running
  function automatic logic [css_pkg::EN_W-1:0] src_needs(input logic [2:0] code);
    logic [css_pkg::EN_W-1:0] m;
    m = '0;
    case (code)
      css_pkg::SRC_FAST_RC: m[css_pkg::EN_FAST_RC] = 1'b1;
      css_pkg::SRC_FAST_RC_DIV: m[css_pkg::EN_FAST_RC] = 1'b1;
      css_pkg::SRC_FAST_RC_PLL:
      begin
        m[css_pkg::EN_FAST_RC] = 1'b1;
        m[css_pkg::EN_PLL] = 1'b1;
      end
      css_pkg::SRC_PRIMARY: m[css_pkg::EN_PRIMARY] = 1'b1;
      css_pkg::SRC_PRIMARY_PLL:
      begin
        m[css_pkg::EN_PRIMARY] = 1'b1;
        m[css_pkg::EN_PLL] = 1'b1;
      end
      css_pkg::SRC_SECONDARY: m[css_pkg::EN_SECONDARY] = 1'b1;
      css_pkg::SRC_LOW_POWER_RC: m[css_pkg::EN_LOW_POWER_RC] = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction

  // registers
  logic [2:0] cur_q;
  logic [2:0] next_q;
  logic req_q;
  logic sec_en_q;
  logic fail_q;
  logic lock_q;
  logic sel_lock_q;
  logic [css_pkg::TRIM_W-1:0] trim_q;
  logic [1:0] hi_stage_q;
  logic [1:0] lo_stage_q;
  logic cfg_loaded_q;
  logic [1:0] submode_q;
  logic sw_disable_q;
  css_pkg::css_state_e state_q;
  css_pkg::css_state_e state_d;
  logic [3:0] cnt_q;
  logic [15:0] rdata_q;

  // synchronisers for the asynchronous status pins
  logic [1:0] ready_sync_q;
  logic [1:0] lock_sync_q;
  logic [1:0] fail_sync_q;
  logic [2:0] nclk_sync_q;

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ready_sync_q <= 2'h0;
      lock_sync_q <= 2'h0;
      fail_sync_q <= 2'h0;
      nclk_sync_q <= 3'h0;
    end
    else if (CE_IN)
    begin
      ready_sync_q <= {ready_sync_q[0], SRC_READY_IN};
      lock_sync_q <= {lock_sync_q[0], PLL_LOCK_IN};
      fail_sync_q <= {fail_sync_q[0], CLOCK_FAIL_IN};
      nclk_sync_q <= {nclk_sync_q[1:0], NEW_CLK_IN};
    end
  end

  wire src_ready = ready_sync_q[1];
  wire pll_locked = lock_sync_q[1];
  wire clk_failed = fail_sync_q[1];
  // edge taken between second and third flop, never on the first
  wire nclk_rise = nclk_sync_q[1] & ~nclk_sync_q[2];

  // switching is enabled only while the config bit is 0
  wire sw_enabled = cfg_loaded_q & ~sw_disable_q;
  wire monitor_on = sw_enabled; // monitor shares the same enable
  wire sel_locked = monitor_on & sel_lock_q;

  // write decode
  wire wr_lo = WR_IN & (ADDR_IN == css_pkg::ADDR_CTRL_LO);
  wire wr_hi = WR_IN & (ADDR_IN == css_pkg::ADDR_CTRL_HI);
  wire wr_trim = WR_IN & (ADDR_IN == css_pkg::ADDR_TRIM);
  wire [7:0] wbyte = WDATA_IN[7:0];
  // a guarded write lands only on the write right after the two keys
  wire hi_open = wr_hi & (hi_stage_q == 2'h2);
  wire lo_open = wr_lo & (lo_stage_q == 2'h2);
  wire next_wr = hi_open & sw_enabled & ~req_q & ~sel_locked;
  wire req_wr = lo_open & sw_enabled & ~sel_locked & wbyte[css_pkg::BIT_SWITCH_REQ];

  // unlock key trackers: any other write breaks the chain
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      hi_stage_q <= 2'h0;
      lo_stage_q <= 2'h0;
    end
    else if (CE_IN && WR_IN)
    begin
      hi_stage_q <= (wr_hi && wbyte == css_pkg::KEY_HI_1) ? 2'h1 :
                    (wr_hi && hi_stage_q == 2'h1 && wbyte == css_pkg::KEY_HI_2) ? 2'h2 :
                    2'h0;
      lo_stage_q <= (wr_lo && wbyte == css_pkg::KEY_LO_1) ? 2'h1 :
                    (wr_lo && lo_stage_q == 2'h1 && wbyte == css_pkg::KEY_LO_2) ? 2'h2 :
                    2'h0;
    end
  end

  // config capture after reset release; a strap is never loaded by the reset itself
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cfg_loaded_q <= 1'b0;
      sw_disable_q <= 1'b1;
      submode_q <= 2'h0;
    end
    else if (CE_IN && !cfg_loaded_q)
    begin
      cfg_loaded_q <= 1'b1;
      sw_disable_q <= CFG_IN.switch_enable_cfg;
      submode_q <= CFG_IN.primary_submode_cfg;
    end
  end

  // sequencer next state; the core keeps running, nothing here stalls it
  wire same_src = (cur_q == next_q);
  // named masks, since a bit cannot be picked straight off a function call
  wire [css_pkg::EN_W-1:0] next_needs = src_needs(next_q);
  wire [css_pkg::EN_W-1:0] cur_needs = src_needs(cur_q);
  wire needs_pll = next_needs[css_pkg::EN_PLL];
  wire new_ready = src_ready & (~needs_pll | pll_locked);
  wire cnt_done = nclk_rise & (cnt_q == 4'(css_pkg::NEW_CLK_CYCLES - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      css_pkg::SW_IDLE: if (req_q) state_d = css_pkg::SW_START;
      css_pkg::SW_START: state_d = same_src ? css_pkg::SW_IDLE : css_pkg::SW_WAIT_READY;
      css_pkg::SW_WAIT_READY: if (new_ready) state_d = css_pkg::SW_COUNT;
      css_pkg::SW_COUNT: if (cnt_done) state_d = css_pkg::SW_DONE;
      css_pkg::SW_DONE: state_d = css_pkg::SW_IDLE;
      default: state_d = css_pkg::SW_IDLE;
    endcase
  end

  wire sw_start_valid = (state_q == css_pkg::SW_START) & ~same_src;
  wire sw_abort = (state_q == css_pkg::SW_START) & same_src;
  wire sw_done = (state_q == css_pkg::SW_DONE);

  // sequencer state and new-clock cycle counter
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_q <= css_pkg::SW_IDLE;
      cnt_q <= 4'h0;
    end
    else if (CE_IN)
    begin
      state_q <= sw_enabled ? state_d : css_pkg::SW_IDLE;
      if (state_q != css_pkg::SW_COUNT)
        cnt_q <= 4'h0;
      else if (nclk_rise)
        cnt_q <= cnt_q + 4'h1;
    end
  end

  // selection fields: current follows initial cfg, later copied from next
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cur_q <= css_pkg::SRC_FAST_RC_DIV;
      next_q <= css_pkg::SRC_FAST_RC_DIV;
    end
    else if (CE_IN)
    begin
      if (!cfg_loaded_q)
      begin
        cur_q <= CFG_IN.initial_source_cfg;
        next_q <= CFG_IN.initial_source_cfg;
      end
      else
      begin
        if (sw_done)
          cur_q <= next_q;
        if (next_wr)
          next_q <= WDATA_IN[2:0];
      end
    end
  end

  // low-byte control and status bits
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      req_q <= 1'b0;
      sec_en_q <= 1'b0;
      fail_q <= 1'b0;
      sel_lock_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      // disabled switching pins the request at zero
      if (!sw_enabled)
        req_q <= 1'b0;
      else if (sw_abort || sw_done)
        req_q <= 1'b0;
      else if (req_wr)
        req_q <= 1'b1;
      if (lo_open)
        sec_en_q <= wbyte[css_pkg::BIT_SEC_EN];
      if (lo_open && wbyte[css_pkg::BIT_SEL_LOCK])
        sel_lock_q <= 1'b1; // set-only
      // monitor set beats any clear in the same cycle
      if (monitor_on && clk_failed)
        fail_q <= 1'b1;
      else if (sw_start_valid || (lo_open && !wbyte[css_pkg::BIT_CLK_FAIL]))
        fail_q <= 1'b0;
      // lock cleared at switch start and in non-pll modes
      if (sw_start_valid)
        lock_q <= 1'b0;
      else if (state_q == css_pkg::SW_IDLE)
        lock_q <= cur_needs[css_pkg::EN_PLL] & pll_locked;
      else
        lock_q <= needs_pll & pll_locked;
    end
  end

  // trim register
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
      trim_q <= css_pkg::TRIM_RESET;
    else if (CE_IN && wr_trim)
      trim_q <= WDATA_IN[css_pkg::TRIM_W-1:0];
  end

  // read mux: unused and unimplemented bits read zero
  wire [15:0] ctrl_word = {1'b0, cur_q, 1'b0, next_q, sel_lock_q, 1'b0, lock_q,
                           1'b0, fail_q, 1'b0, sec_en_q, req_q};
  wire [15:0] rd_mux = (ADDR_IN == css_pkg::ADDR_CTRL_LO) ? ctrl_word :
                       (ADDR_IN == css_pkg::ADDR_CTRL_HI) ? {8'h00, ctrl_word[15:8]} :
                       (ADDR_IN == css_pkg::ADDR_TRIM) ? {10'h000, trim_q} :
                       16'h0000;

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
      rdata_q <= 16'h0000;
    else if (CE_IN)
      rdata_q <= RD_IN ? rd_mux : 16'h0000;
  end

  // enables: current, plus target in the ready wait and count states, plus kept sources
  wire switching = (state_q == css_pkg::SW_WAIT_READY) | (state_q == css_pkg::SW_COUNT);
  wire [css_pkg::EN_W-1:0] keep_mask =
    ({css_pkg::EN_W{WDT_EN_IN | monitor_on}} & src_needs(css_pkg::SRC_LOW_POWER_RC)) |
    ({css_pkg::EN_W{sec_en_q}} & src_needs(css_pkg::SRC_SECONDARY));
  wire [css_pkg::EN_W-1:0] en_mask = src_needs(cur_q) |
    (switching ? src_needs(next_q) : '0) | keep_mask;

  assign RDATA_OUT = rdata_q;
  assign OSC_EN_OUT = en_mask;
  assign SYS_CLK_SEL_OUT = cur_q;
  assign PRI_SUBMODE_OUT = submode_q;
  assign TRIM_OUT = trim_q;

  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_lo_unlock;
    WR_IN && ADDR_IN == css_pkg::ADDR_CTRL_LO && WDATA_IN[7:0] == css_pkg::KEY_LO_1 && CE_IN
    ##1 WR_IN && ADDR_IN == css_pkg::ADDR_CTRL_LO && WDATA_IN[7:0] == css_pkg::KEY_LO_2 && CE_IN;
  endsequence

  chk_req_disabled: assert property (cfg_loaded_q && sw_disable_q |-> !req_q)
    else $error("request bit set while switching disabled");
  chk_req_unlocked: assert property ($rose(req_q) |-> $past(lo_stage_q) == 2'h2)
    else $error("request set without low-byte unlock");
  chk_lo_unlock_set: assert property (s_lo_unlock ##1 (wr_lo && CE_IN && sw_enabled
    && !sel_locked && WDATA_IN[0] && !sw_abort && !sw_done) |=> req_q)
    else $error("unlocked request write lost");
  chk_next_frozen: assert property (req_q && CE_IN && $past(req_q) |=> $stable(next_q))
    else $error("next selection changed during switch");
  chk_redundant_abort: assert property (sw_abort && CE_IN
    |=> !req_q && cur_q == $past(cur_q))
    else $error("redundant switch not aborted");
  chk_start_clears: assert property (sw_start_valid && CE_IN && !clk_failed
    |=> !lock_q && !fail_q)
    else $error("switch start did not clear status");
  chk_done_copy: assert property (sw_done && CE_IN
    |=> !req_q && cur_q == $past(next_q))
    else $error("switch completion wrong");
  chk_count_ten: assert property ($rose(sw_done)
    |-> $past(cnt_q) == 4'(css_pkg::NEW_CLK_CYCLES - 1))
    else $error("changed over before ten new-clock cycles");
  chk_fail_set: assert property (monitor_on && clk_failed && CE_IN |=> fail_q)
    else $error("clock failure not flagged");
  // written trim value read back later, upper bits zero
  chk_trim_upper: assert property (wr_trim && CE_IN ##1 !wr_trim ##1 RD_IN && CE_IN
    && ADDR_IN == css_pkg::ADDR_TRIM |=> RDATA_OUT == {10'h000, $past(WDATA_IN[5:0], 3)})
    else $error("trim upper bits not zero");

endmodule

// file: sim/css_osc_model.sv
// oscillator model: answers the switcher's enables with ready, lock and a new clock
// assumes the bench system clock; startup is counted in system cycles
`timescale 1ns/10ps
module css_osc_model
#(
  parameter int STARTUP = 20
)
(
  input wire logic clk_in, // system clock
  input wire logic rst_in, // async reset, active high
  input wire logic [css_pkg::EN_W-1:0] osc_en_in, // enables from the switcher
  input wire logic hold_lock_in, // bench keeps the pll out of lock
  output logic src_ready_out, // started source is past startup
  output logic pll_lock_out, // pll locked
  output logic new_clk_out // free-running clock of the new source
);
  logic [css_pkg::EN_W-1:0] en_q;
  logic [7:0] cnt_q;
  logic [2:0] div_q;
  wire gained = |(osc_en_in & ~en_q);

  // startup restarts whenever a source is newly enabled, so ready is never stale
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      en_q <= '0;
      cnt_q <= 8'h00;
      div_q <= 3'h0;
    end
    else
    begin
      en_q <= osc_en_in;
      cnt_q <= gained ? 8'h00 : (cnt_q < 8'(STARTUP) ? cnt_q + 8'h01 : cnt_q);
      div_q <= div_q + 3'h1;
    end
  end

  // lock only once the pll is enabled, started, and not held off by the bench
  assign src_ready_out = !gained && (cnt_q >= 8'(STARTUP));
  assign pll_lock_out = src_ready_out && osc_en_in[css_pkg::EN_PLL] && !hold_lock_in;
  // new clock is eight system cycles a period, slow enough to be counted
  assign new_clk_out = div_q[2];
endmodule

// file: sim/clock_source_switcher_test.sv
// self-checking bench for the clock source switcher
// assumes css_pkg and the oscillator model are compiled first
`timescale 1ns/10ps
module clock_source_switcher_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wdt_en = 1'b0;
  logic clk_fail = 1'b0;
  logic hold_lock = 1'b0;
  logic ce = 1'b1;
  css_pkg::css_cfg_s cfg = '{1'b0, 3'h0, 2'h1};
  logic [15:0] rdata;
  logic [css_pkg::EN_W-1:0] osc_en;
  logic [2:0] sel;
  logic [1:0] submode;
  logic [5:0] trim;
  logic ready;
  logic lock;
  logic nclk;
  logic [15:0] r;
  logic [15:0] tv [3] = '{16'hffe0, 16'h001f, 16'h0000};
  logic [2:0] seq [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h0, 3'h4, 3'h5, 3'h7};
  int mismatches = 0;
  int check_count = 0;

  css_switcher uut (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CFG_IN(cfg),
    .WDT_EN_IN(wdt_en), .SRC_READY_IN(ready), .PLL_LOCK_IN(lock), .NEW_CLK_IN(nclk),
    .CLOCK_FAIL_IN(clk_fail), .OSC_EN_OUT(osc_en), .SYS_CLK_SEL_OUT(sel),
    .PRI_SUBMODE_OUT(submode), .TRIM_OUT(trim));
  css_osc_model osc (.clk_in(clk), .rst_in(rst), .osc_en_in(osc_en), .hold_lock_in(hold_lock),
    .src_ready_out(ready), .pll_lock_out(lock), .new_clk_out(nclk));

  // 25 MHz system clock
  always #20 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // two keys and the guarded value on three back-to-back write cycles
  task automatic guarded(input logic [1:0] a, input logic [7:0] k1, input logic [7:0] k2,
    input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {8'h00, k1};
    wr <= 1'b1;
    @(posedge clk);
    wdata <= {8'h00, k2};
    @(posedge clk);
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic fail_pulse;
    @(posedge clk);
    clk_fail <= 1'b1;
    repeat (4) @(posedge clk);
    clk_fail <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [4:0] en_of(input logic [2:0] c);
    case (c)
      3'h1: en_of = 5'h11;
      3'h2: en_of = 5'h02;
      3'h3: en_of = 5'h12;
      3'h4: en_of = 5'h04;
      3'h5: en_of = 5'h08;
      default: en_of = 5'h01;
    endcase
  endfunction

  task automatic do_switch(input logic [2:0] code, input logic hold);
    int n;
    n = 0;
    hold_lock <= hold;
    guarded(2'h1, css_pkg::KEY_HI_1, css_pkg::KEY_HI_2, {13'h0, code});
    rd_reg(2'h0, r);
    chk("next sel", {13'h0, r[10:8]}, {13'h0, code});
    guarded(2'h0, css_pkg::KEY_LO_1, css_pkg::KEY_LO_2, 16'h0001);
    rd_reg(2'h0, r);
    chk("req set", {15'h0, r[0]}, 16'h0001);
    guarded(2'h1, css_pkg::KEY_HI_1, css_pkg::KEY_HI_2, {13'h0, ~code});
    rd_reg(2'h0, r);
    chk("next frozen", {13'h0, r[10:8]}, {13'h0, code});
    if (hold)
    begin
      repeat (150) @(posedge clk);
      rd_reg(2'h0, r);
      chk("wait lock", {14'h0, r[5], r[0]}, 16'h0001);
      hold_lock <= 1'b0;
    end
    repeat (40) @(posedge clk);
    rd_reg(2'h0, r);
    chk("count wait", {15'h0, r[0]}, 16'h0001);
    // poll with a bound, then judge by the request bit
    while (r[0] === 1'b1 && n < 200)
    begin
      rd_reg(2'h0, r);
      n++;
    end
    chk("req done", {15'h0, r[0]}, 16'h0000);
    chk("cur sel", {13'h0, r[14:12]}, {13'h0, code});
    chk("lock bit", {15'h0, r[5]}, {15'h0, code == 3'h1 || code == 3'h3});
    chk("fail bit", {15'h0, r[3]}, 16'h0000);
    chk("sys sel", {13'h0, sel}, {13'h0, code});
    chk("osc en", {11'h0, osc_en}, {11'h0, en_of(code) | 5'h08});
    chk("submode", {14'h0, submode}, {14'h0, cfg.primary_submode_cfg});
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial
  begin
    #(40 * 30000);
    mismatches++;
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(css_pkg::ADDR_TRIM, r);
    chk("trim reset", r, 16'h0000);
    foreach (tv[i])
    begin
      wr_reg(css_pkg::ADDR_TRIM, tv[i]);
      rd_reg(css_pkg::ADDR_TRIM, r);
      chk("trim read", r, tv[i] & 16'h003f);
      chk("trim out", {10'h0, trim}, tv[i] & 16'h003f);
    end
    // a write with the clock enable low must leave the trim alone
    ce <= 1'b0;
    wr_reg(css_pkg::ADDR_TRIM, 16'h0015);
    ce <= 1'b1;
    rd_reg(css_pkg::ADDR_TRIM, r);
    chk("trim frozen", r, 16'h0000);
    rd_reg(2'h0, r);
    chk("ctrl reset", r, 16'h0000);
    // broken chain and swapped keys must both be dropped
    wr_reg(2'h1, 16'h0078);
    wr_reg(2'h2, 16'h0000);
    wr_reg(2'h1, 16'h009a);
    wr_reg(2'h1, 16'h0002);
    guarded(2'h1, css_pkg::KEY_HI_2, css_pkg::KEY_HI_1, 16'h0002);
    rd_reg(2'h0, r);
    chk("no unlock", {13'h0, r[10:8]}, 16'h0000);
    guarded(2'h0, css_pkg::KEY_LO_1, css_pkg::KEY_LO_2, 16'h0001);
    repeat (8) @(posedge clk);
    rd_reg(2'h0, r);
    chk("redundant", {15'h0, r[0]}, 16'h0000);
    fail_pulse();
    rd_reg(2'h0, r);
    chk("fail set", {15'h0, r[3]}, 16'h0001);
    // every source code but the reserved one; each pll mode entered from its plain source (fast rc, primary)
    foreach (seq[i])
      do_switch(seq[i], seq[i] == 3'h1 || seq[i] == 3'h3);
    guarded(2'h0, css_pkg::KEY_LO_1, css_pkg::KEY_LO_2, 16'h0080);
    guarded(2'h1, css_pkg::KEY_HI_1, css_pkg::KEY_HI_2, 16'h0000);
    rd_reg(2'h0, r);
    chk("sel locked", {13'h0, r[10:8]}, 16'h0007);
    chk("lock bit set", {15'h0, r[7]}, 16'h0001);
    // second reset with switching disabled and another initial source
    @(posedge clk);
    rst <= 1'b1;
    cfg <= '{1'b1, 3'h5, 2'h2};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(2'h0, r);
    chk("cur initial", {13'h0, r[14:12]}, 16'h0005);
    guarded(2'h1, css_pkg::KEY_HI_1, css_pkg::KEY_HI_2, 16'h0000);
    guarded(2'h0, css_pkg::KEY_LO_1, css_pkg::KEY_LO_2, 16'h0001);
    rd_reg(2'h0, r);
    chk("req held", {15'h0, r[0]}, 16'h0000);
    chk("next ignored", {13'h0, r[10:8]}, 16'h0005);
    repeat (150) @(posedge clk);
    fail_pulse();
    rd_reg(2'h0, r);
    chk("cur kept", {13'h0, r[14:12]}, 16'h0005);
    chk("no monitor", {15'h0, r[3]}, 16'h0000);
    chk("sys kept", {13'h0, sel}, 16'h0005);
    chk("submode cfg", {14'h0, submode}, 16'h0002);
    end_sim();
  end
endmodule
